// *** verilog/etcs_pkg.sv ***
package etcs_pkg;

    // Host data address width and register width
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 8;

    // Register addresses in the host data space
    localparam logic [11:0] ADDR_ETH_CONTROL_ONE = 12'hf9e;
    localparam logic [11:0] ADDR_ETH_CONTROL_TWO = 12'he7e;
    localparam logic [11:0] ADDR_ETH_STATUS      = 12'he7d;
    localparam logic [11:0] ADDR_MAC_CONTROL_ONE = 12'he80;

    // MAC and MII management windows routed into the MAC, all but MAC control register one at 12'he80
    localparam logic [11:0] MAC_WIN_A_LO = 12'he80;
    localparam logic [11:0] MAC_WIN_A_HI = 12'he85;
    localparam logic [11:0] MAC_WIN_B    = 12'he8a;
    localparam logic [11:0] MAC_WIN_C_LO = 12'hea0;
    localparam logic [11:0] MAC_WIN_C_HI = 12'heb9;

    // Control register one fields
    localparam int unsigned BIT_TRANSMIT_RESET   = 7;
    localparam int unsigned BIT_RECEIVE_RESET    = 6;
    localparam int unsigned BIT_DMA_START_BUSY   = 5;
    localparam int unsigned BIT_CHECKSUM_SELECT  = 4;
    localparam int unsigned BIT_TRANSMIT_REQUEST = 3;
    localparam int unsigned BIT_RECEIVE_ENABLE   = 2;

    // Control register two fields
    localparam int unsigned BIT_POINTER_AUTO_INCREMENT = 7;
    localparam int unsigned BIT_PACKET_COUNT_DECREMENT = 6;
    localparam int unsigned BIT_MODULE_ENABLE          = 5;

    // Status register fields
    localparam int unsigned BIT_BUFFER_ERROR_FLAG   = 6;
    localparam int unsigned BIT_RECEIVE_ACTIVE      = 2;
    localparam int unsigned BIT_TRANSMIT_ABORT_FLAG = 1;
    localparam int unsigned BIT_PHY_CLOCK_READY     = 0;

    // MAC control register one fields
    localparam int unsigned BIT_PAUSE_TRANSMIT_ENABLE = 3;
    localparam int unsigned BIT_PAUSE_RECEIVE_ENABLE  = 2;
    localparam int unsigned BIT_PASS_CONTROL_FRAMES   = 1;
    localparam int unsigned BIT_MAC_RECEIVE_ENABLE    = 0;

    // Values after reset
    localparam logic [7:0] RST_ETH_CONTROL_ONE = 8'h00;
    localparam logic [7:0] RST_ETH_CONTROL_TWO = 8'h80;
    localparam logic [7:0] RST_ETH_STATUS      = 8'h00;
    localparam logic [7:0] RST_MAC_CONTROL_ONE = 8'h00;

    // PHY start-up timer
    localparam int unsigned CLK_PERIOD_NS       = 10;
    localparam int unsigned PHY_START_TIME_NS   = 300000;
    localparam int unsigned PHY_START_CYCLES    =
        (PHY_START_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PHY_TIMER_W         = 20;

endpackage : etcs_pkg

// *** verilog/etcs_phy_timer.sv ***
`timescale 1ns/10ps
module etcs_phy_timer
    import etcs_pkg::*;
#(
    parameter int unsigned CYCLES = PHY_START_CYCLES
) (
    input  wire logic clk_sys_in,
    input  wire logic sys_rst_in,
    input  wire logic run_in,
    output logic      ready_out
);

    logic [PHY_TIMER_W-1:0] count_r;
    logic [PHY_TIMER_W-1:0] count_nxt;
    logic                   expired;

    // Terminal count reached
    assign expired   = (count_r >= PHY_TIMER_W'(CYCLES - 1));
    // Restart whenever the module is off, hold once expired
    assign count_nxt = !run_in ? '0 :
                       expired ? count_r : count_r + PHY_TIMER_W'(1);

    // Start-up counter and ready flag
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            count_r   <= '0;
            ready_out <= 1'b0;
        end else begin
            count_r   <= count_nxt;
            ready_out <= run_in & expired;
        end
    end

endmodule : etcs_phy_timer

// *** verilog/etcs_top.sv ***
`timescale 1ns/10ps
module etcs_top
    import etcs_pkg::*;
#(
    parameter int unsigned PHY_CYCLES = PHY_START_CYCLES
) (
    input  wire logic        clk_sys_in,
    input  wire logic        sys_rst_in,
    input  wire logic [11:0] sfr_addr_in,
    input  wire logic        sfr_wr_in,
    input  wire logic        sfr_rd_in,
    input  wire logic [7:0]  sfr_wdata_in,
    output logic [7:0]       sfr_rdata_out,
    output logic             sfr_rvalid_out,
    output logic             mac_strobe_out,
    output logic             mac_we_out,
    output logic [11:0]      mac_addr_out,
    output logic [7:0]       mac_wdata_out,
    input  wire logic [7:0]  mac_rdata_in,
    input  wire logic        dma_done_in,
    input  wire logic        tx_done_in,
    input  wire logic        tx_abort_in,
    input  wire logic        rx_busy_in,
    input  wire logic        tx_buf_fail_in,
    input  wire logic        rx_buf_fail_in,
    input  wire logic        data_port_rd_in,
    input  wire logic        data_port_wr_in,
    output logic             transmit_reset_out,
    output logic             receive_reset_out,
    output logic             dma_start_busy_out,
    output logic             checksum_select_out,
    output logic             transmit_request_out,
    output logic             receive_enable_out,
    output logic             module_enable_out,
    output logic             read_pointer_advance_out,
    output logic             write_pointer_advance_out,
    output logic             packet_count_decrement_out,
    output logic             transmit_error_irq_flag_out,
    output logic             receive_error_irq_flag_out,
    output logic             packet_abort_out,
    output logic             pause_transmit_enable_out,
    output logic             pause_receive_enable_out,
    output logic             pass_control_frames_out,
    output logic             mac_receive_enable_out
);

    // Register storage
    logic [7:0] ctl_one_r;
    logic [7:0] ctl_one_nxt;
    logic [7:0] ctl_two_r;
    logic [7:0] ctl_two_nxt;
    logic [7:0] mac_one_r;
    logic [7:0] mac_one_nxt;
    logic       buf_err_r;
    logic       buf_err_nxt;
    logic       tx_abort_r;
    logic       tx_abort_nxt;
    logic       mac_rd_pend_r;
    logic [7:0] rdata_nxt;
    logic       phy_ready;

    // Address decode
    logic       wr_ctl_one;
    logic       wr_ctl_two;
    logic       wr_status;
    logic       wr_mac_one;
    logic       in_mac_win;
    logic       mac_fwd;
    logic [7:0] status_view;
    logic       buf_fail;
    logic       tx_hw_clear;
    logic       dma_hw_clear;
    logic       clr_buf_err;
    logic       clr_tx_abort;

    // Register selects; always live, module enable not consulted
    assign wr_ctl_one = sfr_wr_in && (sfr_addr_in == ADDR_ETH_CONTROL_ONE);
    assign wr_ctl_two = sfr_wr_in && (sfr_addr_in == ADDR_ETH_CONTROL_TWO);
    assign wr_status  = sfr_wr_in && (sfr_addr_in == ADDR_ETH_STATUS);
    assign wr_mac_one = sfr_wr_in && (sfr_addr_in == ADDR_MAC_CONTROL_ONE);

    // MAC and MII windows, minus the register held here
    assign in_mac_win = ((sfr_addr_in >= MAC_WIN_A_LO) && (sfr_addr_in <= MAC_WIN_A_HI))
                     || (sfr_addr_in == MAC_WIN_B)
                     || ((sfr_addr_in >= MAC_WIN_C_LO) && (sfr_addr_in <= MAC_WIN_C_HI));
    assign mac_fwd    = in_mac_win && (sfr_addr_in != ADDR_MAC_CONTROL_ONE)
                     && (sfr_wr_in || sfr_rd_in);

    // Any buffer access failure
    assign buf_fail     = tx_buf_fail_in | rx_buf_fail_in;
    // Hardware ends of the busy bits
    assign tx_hw_clear  = tx_done_in | tx_abort_in | tx_buf_fail_in;
    assign dma_hw_clear = dma_done_in;

    // Control register one: software write wins, else hardware clears busy bits
    always_comb begin
        ctl_one_nxt = ctl_one_r;
        if (dma_hw_clear) begin
            ctl_one_nxt[BIT_DMA_START_BUSY] = 1'b0;
        end
        if (tx_hw_clear) begin
            ctl_one_nxt[BIT_TRANSMIT_REQUEST] = 1'b0;
        end
        if (wr_ctl_one) begin
            ctl_one_nxt = {sfr_wdata_in[7:2], 2'b00};
        end
        // Transmit reset overrides any request, written or held
        if (ctl_one_nxt[BIT_TRANSMIT_RESET]) begin
            ctl_one_nxt[BIT_TRANSMIT_REQUEST] = 1'b0;
        end
    end

    // Control register two: decrement bit never stays set
    always_comb begin
        ctl_two_nxt = ctl_two_r;
        ctl_two_nxt[BIT_PACKET_COUNT_DECREMENT] = 1'b0;
        if (wr_ctl_two) begin
            ctl_two_nxt = {sfr_wdata_in[7:5], 5'b00000};
        end
    end

    // MAC control register one: reserved and unimplemented bits stay zero
    assign mac_one_nxt = wr_mac_one ? {4'h0, sfr_wdata_in[3:0]} : mac_one_r;

    // Software clears: a written zero on a clearable flag
    assign clr_buf_err  = wr_status & ~sfr_wdata_in[BIT_BUFFER_ERROR_FLAG];
    assign clr_tx_abort = wr_status & ~sfr_wdata_in[BIT_TRANSMIT_ABORT_FLAG];

    // Sticky flags: event set beats a software clear
    assign buf_err_nxt  = buf_fail | (buf_err_r & ~clr_buf_err);
    assign tx_abort_nxt = tx_abort_in | (tx_abort_r & ~clr_tx_abort);

    // Status view; reserved bit 4 and unimplemented bits read zero
    always_comb begin
        status_view = 8'h00;
        status_view[BIT_BUFFER_ERROR_FLAG]   = buf_err_r;
        status_view[BIT_RECEIVE_ACTIVE]      = rx_busy_in;
        status_view[BIT_TRANSMIT_ABORT_FLAG] = tx_abort_r;
        status_view[BIT_PHY_CLOCK_READY]     = phy_ready;
    end

    // Read data selection
    always_comb begin
        rdata_nxt = sfr_rdata_out;
        if (mac_rd_pend_r) begin
            rdata_nxt = mac_rdata_in;
        end else if (sfr_rd_in) begin
            case (sfr_addr_in)
                ADDR_ETH_CONTROL_ONE: rdata_nxt = ctl_one_r;
                ADDR_ETH_CONTROL_TWO: rdata_nxt = ctl_two_r;
                ADDR_ETH_STATUS:      rdata_nxt = status_view;
                ADDR_MAC_CONTROL_ONE: rdata_nxt = mac_one_r;
                default:              rdata_nxt = 8'h00;
            endcase
        end
    end

    // PHY start-up timer runs while the module is enabled
    etcs_phy_timer #(
        .CYCLES    (PHY_CYCLES)
    ) u_phy_timer (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .run_in    (ctl_two_r[BIT_MODULE_ENABLE]),
        .ready_out (phy_ready)
    );

    // Control register state
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ctl_one_r  <= RST_ETH_CONTROL_ONE;
            ctl_two_r  <= RST_ETH_CONTROL_TWO;
            mac_one_r  <= RST_MAC_CONTROL_ONE;
        end else begin
            ctl_one_r  <= ctl_one_nxt;
            ctl_two_r  <= ctl_two_nxt;
            mac_one_r  <= mac_one_nxt;
        end
    end

    // Sticky status flags
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            buf_err_r  <= 1'b0;
            tx_abort_r <= 1'b0;
        end else begin
            buf_err_r  <= buf_err_nxt;
            tx_abort_r <= tx_abort_nxt;
        end
    end

    // Host read port
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sfr_rdata_out  <= 8'h00;
            sfr_rvalid_out <= 1'b0;
            mac_rd_pend_r  <= 1'b0;
        end else begin
            sfr_rdata_out  <= rdata_nxt;
            sfr_rvalid_out <= mac_rd_pend_r | (sfr_rd_in & ~mac_fwd);
            mac_rd_pend_r  <= mac_fwd & sfr_rd_in;
        end
    end

    // Forwarding into the MAC
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            mac_strobe_out <= 1'b0;
            mac_we_out     <= 1'b0;
            mac_addr_out   <= 12'h000;
            mac_wdata_out  <= 8'h00;
        end else begin
            mac_strobe_out <= mac_fwd;
            mac_we_out     <= mac_fwd & sfr_wr_in;
            if (mac_fwd) begin
                mac_addr_out  <= sfr_addr_in;
                mac_wdata_out <= sfr_wdata_in;
            end
        end
    end

    // Control outputs toward the engines and the MAC
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            transmit_reset_out        <= 1'b0;
            receive_reset_out         <= 1'b0;
            dma_start_busy_out        <= 1'b0;
            checksum_select_out       <= 1'b0;
            transmit_request_out      <= 1'b0;
            receive_enable_out        <= 1'b0;
            module_enable_out         <= 1'b0;
        end else begin
            transmit_reset_out        <= ctl_one_nxt[BIT_TRANSMIT_RESET];
            receive_reset_out         <= ctl_one_nxt[BIT_RECEIVE_RESET];
            dma_start_busy_out        <= ctl_one_nxt[BIT_DMA_START_BUSY];
            checksum_select_out       <= ctl_one_nxt[BIT_CHECKSUM_SELECT];
            transmit_request_out      <= ctl_one_nxt[BIT_TRANSMIT_REQUEST];
            receive_enable_out        <= ctl_one_nxt[BIT_RECEIVE_ENABLE]
                                       & ~ctl_one_nxt[BIT_RECEIVE_RESET];
            module_enable_out         <= ctl_two_nxt[BIT_MODULE_ENABLE];
        end
    end

    // MAC control outputs
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pause_transmit_enable_out <= 1'b0;
            pause_receive_enable_out  <= 1'b0;
            pass_control_frames_out   <= 1'b0;
            mac_receive_enable_out    <= 1'b0;
        end else begin
            pause_transmit_enable_out <= mac_one_nxt[BIT_PAUSE_TRANSMIT_ENABLE];
            pause_receive_enable_out  <= mac_one_nxt[BIT_PAUSE_RECEIVE_ENABLE];
            pass_control_frames_out   <= mac_one_nxt[BIT_PASS_CONTROL_FRAMES];
            mac_receive_enable_out    <= mac_one_nxt[BIT_MAC_RECEIVE_ENABLE]
                                       & ~ctl_one_nxt[BIT_RECEIVE_RESET];
        end
    end

    // One-cycle pulses: pointer advance, packet decrement, error flags
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            read_pointer_advance_out    <= 1'b0;
            write_pointer_advance_out   <= 1'b0;
            packet_count_decrement_out  <= 1'b0;
            transmit_error_irq_flag_out <= 1'b0;
            receive_error_irq_flag_out  <= 1'b0;
            packet_abort_out            <= 1'b0;
        end else begin
            read_pointer_advance_out    <= data_port_rd_in
                                         & ctl_two_r[BIT_POINTER_AUTO_INCREMENT];
            write_pointer_advance_out   <= data_port_wr_in
                                         & ctl_two_r[BIT_POINTER_AUTO_INCREMENT];
            packet_count_decrement_out  <= wr_ctl_two
                                         & sfr_wdata_in[BIT_PACKET_COUNT_DECREMENT];
            transmit_error_irq_flag_out <= tx_buf_fail_in;
            receive_error_irq_flag_out  <= rx_buf_fail_in;
            packet_abort_out            <= buf_fail;
        end
    end

endmodule : etcs_top

// *** testbench/etcs_mac_model.sv ***
`timescale 1ns/10ps
module etcs_mac_model (
    input  wire logic        clk_sys_in,
    input  wire logic        strobe_in,
    input  wire logic        we_in,
    input  wire logic [11:0] addr_in,
    input  wire logic [7:0]  wdata_in,
    output logic [7:0]       rdata_out
);
    logic [7:0] mem_r [256];
    logic [7:0] last_r = 8'h00;
    wire  logic rd_sel = strobe_in && !we_in;
    // Store forwarded writes, remember last value read
    always_ff @(posedge clk_sys_in) begin
        if (strobe_in && we_in) mem_r[addr_in[7:0]] <= wdata_in;
        if (rd_sel) last_r <= mem_r[addr_in[7:0]];
    end
    // Data only while selected, else inverse of last value
    assign rdata_out = rd_sel ? mem_r[addr_in[7:0]] : ~last_r;
endmodule : etcs_mac_model

// *** testbench/etcs_top_asserts.sv ***
`timescale 1ns/10ps
module etcs_chk
    import etcs_pkg::*;
(
    input wire logic        clk_sys_in,
    input wire logic        sys_rst_in,
    input wire logic [11:0] sfr_addr_in,
    input wire logic        sfr_wr_in,
    input wire logic        sfr_rd_in,
    input wire logic [7:0]  sfr_wdata_in,
    input wire logic        sfr_rvalid_out,
    input wire logic        mac_strobe_out,
    input wire logic        mac_we_out,
    input wire logic [11:0] mac_addr_out,
    input wire logic [7:0]  mac_wdata_out,
    input wire logic        packet_count_decrement_out,
    input wire logic        tx_buf_fail_in,
    input wire logic        transmit_error_irq_flag_out,
    input wire logic        packet_abort_out,
    input wire logic        tx_done_in,
    input wire logic        transmit_request_out,
    input wire logic        transmit_reset_out,
    input wire logic        receive_reset_out,
    input wire logic        receive_enable_out
);
    // Forwarded window and local register decode
    wire logic win = (sfr_addr_in > MAC_WIN_A_LO && sfr_addr_in <= MAC_WIN_A_HI) ||
        sfr_addr_in == MAC_WIN_B || (sfr_addr_in >= MAC_WIN_C_LO && sfr_addr_in <= MAC_WIN_C_HI);
    wire logic loc = sfr_addr_in inside {ADDR_ETH_CONTROL_ONE, ADDR_ETH_CONTROL_TWO,
        ADDR_ETH_STATUS, ADDR_MAC_CONTROL_ONE};
    wire logic c2_wr = sfr_wr_in && sfr_addr_in == ADDR_ETH_CONTROL_TWO;
    wire logic c1_wr = sfr_wr_in && sfr_addr_in == ADDR_ETH_CONTROL_ONE;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    AST_RD_LOCAL: assert property (
        sfr_rd_in && loc |=> sfr_rvalid_out) else $error("local read not answered");
    AST_MAC_WR: assert property (
        sfr_wr_in && win |=> mac_strobe_out && mac_we_out &&
        mac_addr_out == $past(sfr_addr_in) && mac_wdata_out == $past(sfr_wdata_in))
        else $error("window write not forwarded");
    AST_MAC_RD: assert property (
        sfr_rd_in && win |=> mac_strobe_out && !mac_we_out ##1 sfr_rvalid_out)
        else $error("window read not forwarded");
    AST_PKT_DEC: assert property (
        c2_wr |=> packet_count_decrement_out == $past(sfr_wdata_in[6]) ##1
        !packet_count_decrement_out) else $error("decrement pulse wrong");
    AST_BUF_FAIL: assert property (
        tx_buf_fail_in |=> transmit_error_irq_flag_out && packet_abort_out)
        else $error("buffer failure not flagged");
    AST_TX_DONE: assert property (
        tx_done_in && !c1_wr |=> !transmit_request_out) else $error("request not cleared");
    AST_TX_RST: assert property (
        transmit_reset_out |-> !transmit_request_out) else $error("request during reset");
    AST_RX_RST: assert property (
        receive_reset_out |-> !receive_enable_out) else $error("receive on during reset");
    // Main scenarios
    cover property (sfr_wr_in && win);
    cover property (packet_count_decrement_out);
    cover property (tx_buf_fail_in ##1 packet_abort_out);
endmodule : etcs_chk
bind etcs_top etcs_chk etcs_chk_inst (.*);

// *** testbench/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
    import etcs_pkg::*;
    logic        clk_sys_in, sys_rst_in, sfr_wr_in, sfr_rd_in, rx_busy_in, sfr_rvalid_out;
    logic [11:0] sfr_addr_in, mac_addr_out;
    logic [7:0]  sfr_wdata_in, sfr_rdata_out, mac_rdata_in, mac_wdata_out;
    logic [6:0]  ev_r;
    logic        mac_strobe_out, mac_we_out, dma_done_in, tx_done_in, tx_abort_in;
    logic        tx_buf_fail_in, rx_buf_fail_in, data_port_rd_in, data_port_wr_in;
    logic        transmit_reset_out, receive_reset_out, dma_start_busy_out;
    logic        checksum_select_out, transmit_request_out, receive_enable_out;
    logic        module_enable_out, read_pointer_advance_out, write_pointer_advance_out;
    logic        packet_count_decrement_out, transmit_error_irq_flag_out;
    logic        receive_error_irq_flag_out, packet_abort_out, pause_transmit_enable_out;
    logic        pause_receive_enable_out, pass_control_frames_out, mac_receive_enable_out;
    int          fail_count = 0;
    int          comparisons = 0;
    int          cycles = 0;
    logic [11:0] wa [5] = '{12'he81, MAC_WIN_A_HI, MAC_WIN_B, MAC_WIN_C_LO, MAC_WIN_C_HI};
    // Engine event pulses and packed views of outputs
    assign {dma_done_in, tx_done_in, tx_abort_in, tx_buf_fail_in, rx_buf_fail_in,
        data_port_rd_in, data_port_wr_in} = ev_r;
    wire logic [7:0] ctl1_o = {transmit_reset_out, receive_reset_out, dma_start_busy_out,
        checksum_select_out, transmit_request_out, receive_enable_out, 2'h0};
    wire logic [7:0] misc_o = {module_enable_out, read_pointer_advance_out,
        write_pointer_advance_out, packet_count_decrement_out, transmit_error_irq_flag_out,
        receive_error_irq_flag_out, packet_abort_out, 1'h0};
    wire logic [7:0] mac_o = {4'h0, pause_transmit_enable_out, pause_receive_enable_out,
        pass_control_frames_out, mac_receive_enable_out};
    etcs_top #(.PHY_CYCLES(8)) etcs_top_inst (.*);
    etcs_mac_model etcs_mac_model_inst (.clk_sys_in, .strobe_in(mac_strobe_out),
        .we_in(mac_we_out), .addr_in(mac_addr_out), .wdata_in(mac_wdata_out),
        .rdata_out(mac_rdata_in));
    // Clock
    initial begin
        clk_sys_in = 1'h0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    // Hang guard
    always @(posedge clk_sys_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            close_out();
        end
    end
    task close_out();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out
    task chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One write, always followed by an idle cycle
    task wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        sfr_addr_in <= a;
        sfr_wdata_in <= d;
        sfr_wr_in <= 1'h1;
        @(posedge clk_sys_in) sfr_wr_in <= 1'h0;
        @(negedge clk_sys_in);
    endtask : wr
    task rd(input logic [11:0] a, input logic [7:0] exp);
        int n;
        @(posedge clk_sys_in);
        sfr_addr_in <= a;
        sfr_rd_in <= 1'h1;
        @(posedge clk_sys_in) sfr_rd_in <= 1'h0;
        n = 0;
        do begin
            @(negedge clk_sys_in);
            n++;
        end while (sfr_rvalid_out !== 1'h1 && n < 4);
        chk({7'h0, sfr_rvalid_out}, 8'h01);
        chk(sfr_rdata_out, exp);
    endtask : rd
    task fire(input logic [6:0] m);
        @(posedge clk_sys_in) ev_r <= m;
        @(posedge clk_sys_in) ev_r <= 7'h0;
        @(negedge clk_sys_in);
    endtask : fire
    // Main sequence
    initial begin
        sys_rst_in = 1'h1;
        {sfr_wr_in, sfr_rd_in, rx_busy_in, sfr_addr_in, sfr_wdata_in, ev_r} = 30'h0;
        repeat (2) @(posedge clk_sys_in);
        sys_rst_in <= 1'h0;
        rd(ADDR_ETH_CONTROL_ONE, 8'h00);
        rd(ADDR_ETH_CONTROL_TWO, 8'h80);
        rd(ADDR_ETH_STATUS, 8'h00);
        rd(ADDR_MAC_CONTROL_ONE, 8'h00);
        rd(12'h123, 8'h00);
        wr(ADDR_ETH_CONTROL_ONE, 8'hff);
        rd(ADDR_ETH_CONTROL_ONE, 8'hf4);
        chk(ctl1_o, 8'hf0);
        wr(ADDR_ETH_CONTROL_ONE, 8'h3c);
        chk(ctl1_o, 8'h3c);
        fire(7'h20);
        rd(ADDR_ETH_CONTROL_ONE, 8'h34);
        fire(7'h40);
        rd(ADDR_ETH_CONTROL_ONE, 8'h14);
        wr(ADDR_ETH_CONTROL_ONE, 8'h2c);
        fire(7'h10);
        chk(ctl1_o, 8'h24);
        wr(ADDR_ETH_CONTROL_ONE, 8'h04);
        rd(ADDR_ETH_CONTROL_ONE, 8'h04);
        rd(ADDR_ETH_STATUS, 8'h02);
        wr(ADDR_ETH_CONTROL_TWO, 8'h20);
        fire(7'h03);
        chk(misc_o, 8'h80);
        wr(ADDR_ETH_CONTROL_TWO, 8'ha0);
        fire(7'h01);
        chk(misc_o, 8'ha0);
        fire(7'h02);
        chk(misc_o, 8'hc0);
        wr(ADDR_ETH_CONTROL_TWO, 8'he0);
        chk(misc_o, 8'h90);
        rd(ADDR_ETH_CONTROL_TWO, 8'ha0);
        rd(ADDR_ETH_STATUS, 8'h03);
        fire(7'h08);
        chk(misc_o, 8'h8a);
        fire(7'h04);
        chk(misc_o, 8'h86);
        @(posedge clk_sys_in) rx_busy_in <= 1'h1;
        rd(ADDR_ETH_STATUS, 8'h47);
        wr(ADDR_ETH_STATUS, 8'h47);
        rd(ADDR_ETH_STATUS, 8'h47);
        wr(ADDR_ETH_STATUS, 8'h00);
        rd(ADDR_ETH_STATUS, 8'h05);
        wr(ADDR_ETH_CONTROL_TWO, 8'h80);
        rd(ADDR_ETH_CONTROL_TWO, 8'h80);
        rd(ADDR_ETH_STATUS, 8'h04);
        wr(ADDR_ETH_CONTROL_TWO, 8'h20);
        wr(ADDR_MAC_CONTROL_ONE, 8'hff);
        rd(ADDR_MAC_CONTROL_ONE, 8'h0f);
        chk(mac_o, 8'h0f);
        // Window accesses with the module enabled
        foreach (wa[i]) begin
            wr(wa[i], ~wa[i][7:0]);
            rd(wa[i], ~wa[i][7:0]);
        end
        wr(12'he86, 8'h11);
        rd(12'he86, 8'h00);
        wr(ADDR_ETH_CONTROL_ONE, 8'h40);
        chk(mac_o, 8'h0e);
        close_out();
    end
endmodule : tb_top
